// ### hdl/serial_port_pkg.sv
`default_nettype none
package serial_port_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] FORMAT_SETUP_IDX  = 4'h0;
  localparam logic [3:0] CONTROL_SETUP_IDX = 4'h1;
  localparam logic [3:0] BAUD_DIV_IDX      = 4'h2;
  localparam logic [3:0] TX_DATA_IDX       = 4'h3;
  localparam logic [3:0] RX_DATA_IDX       = 4'h4;
  localparam logic [3:0] EVENT_STATUS_IDX  = 4'h5;
  localparam logic [3:0] EVENT_MASK_IDX    = 4'h6;
  localparam logic [3:0] FIFO_COUNT_IDX    = 4'h7;
  localparam logic [3:0] LINE_STATUS_IDX   = 4'h8;

  // Format setup fields.
  localparam int CHAR_LEN_BIT   = 6;
  localparam int PARITY_EN_BIT  = 5;
  localparam int PARITY_ODD_BIT = 4;
  localparam int STOP_LEN_BIT   = 3;

  // Control setup fields.
  localparam int TX_EN_BIT      = 5;
  localparam int RX_EN_BIT      = 4;
  localparam int CLK_SRC_BIT    = 1;

  // Line status field.
  localparam int OVERRUN_BIT    = 0;

  // Event status fields.
  localparam int EV_RX_READY    = 0;
  localparam int EV_FRAMING     = 1;
  localparam int EV_PARITY      = 2;
  localparam int EV_BREAK       = 3;
  localparam int EV_RX_FULL     = 4;
  localparam int EV_TX_END      = 5;
  localparam int EV_OVERRUN     = 6;
  localparam int EV_W           = 7;

  // Field positions in the receive data word.
  localparam int RX_FER_POS     = 8;
  localparam int RX_PER_POS     = 9;

  // Reset values.
  localparam logic [15:0] FORMAT_RESET  = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET    = 16'h0000;
  localparam logic [EV_W-1:0] MASK_RESET = 7'h00;

  // Sub-bit timing at sixteen ticks per bit.
  localparam logic [3:0] MID_START_TICK = 4'h7;
  localparam logic [3:0] LAST_SUB_TICK  = 4'hF;

endpackage
`default_nettype wire

// ### hdl/char_fifo.sv
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  full,
  output logic                  empty,
  output logic      [CNT_W-1:0] count
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic             do_push;
  logic             do_pop;

  // A push into a full store or a pop from an empty one is dropped.
  assign do_push = push && (count_q != CNT_W'(DEPTH));
  assign do_pop  = pop && (count_q != '0);
  assign head    = mem_q[rd_ptr_q];
  assign full    = (count_q == CNT_W'(DEPTH));
  assign empty   = (count_q == '0);
  assign count   = count_q;

  // Storage has no reset; only the pointers carry meaning.
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem_q[wr_ptr_q] <= wdata;
    end
  end

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### hdl/fifo_serial_port.sv
// Decided for this implementation: the address map and strobed register access.
`default_nettype none
module fifo_serial_port #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        receive_pin,
  input  wire logic        serial_clock_pin,
  output logic             transmit_pin,
  output logic             irq
);

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int EV_W_L = serial_port_pkg::EV_W - 1;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
  } frame_state_t;

  logic [15:0]     format_q;
  logic [15:0]     control_q;
  logic [15:0]     baud_div_q;
  logic [15:0]     baud_cnt_q;
  logic [EV_W_L:0] events_q;
  logic [EV_W_L:0] mask_q;
  logic            overrun_q;
  logic            overrun_seen_q;
  logic [1:0]      rxd_sync_q;
  logic [2:0]      sck_sync_q;
  logic            baud_tick;
  logic            tick;
  logic [EV_W_L:0] ev_set;

  // Decoded configuration fields.
  logic char7;
  logic par_en;
  logic par_odd;
  logic stop2;
  logic tx_en;
  logic rx_en;
  logic ext_clk;
  assign char7   = format_q[serial_port_pkg::CHAR_LEN_BIT];
  assign par_en  = format_q[serial_port_pkg::PARITY_EN_BIT];
  assign par_odd = format_q[serial_port_pkg::PARITY_ODD_BIT];
  assign stop2   = format_q[serial_port_pkg::STOP_LEN_BIT];
  assign tx_en   = control_q[serial_port_pkg::TX_EN_BIT];
  assign rx_en   = control_q[serial_port_pkg::RX_EN_BIT];
  assign ext_clk = control_q[serial_port_pkg::CLK_SRC_BIT];

  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] i);
    return a == i;
  endfunction

  // Pins come from outside; two stages first, the third only for edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxd_sync_q <= 2'h3;
      sck_sync_q <= 3'h0;
    end else begin
      rxd_sync_q <= {rxd_sync_q[0], receive_pin};
      sck_sync_q <= {sck_sync_q[1:0], serial_clock_pin};
    end
  end

  // The internal generator yields one sub-bit tick every divisor+1 cycles.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      baud_cnt_q <= 16'h0000;
    end else if (baud_tick) begin
      baud_cnt_q <= 16'h0000;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
  end
  assign baud_tick = (baud_cnt_q >= baud_div_q);

  // The external clock must be well below half the core rate to be seen.
  assign tick = ext_clk ? (sck_sync_q[1] && !sck_sync_q[2])
                        : baud_tick;

  // FIFOs.
  logic             tx_push, tx_pop, tx_full, tx_empty;
  logic [7:0]       tx_head;
  logic [CNT_W-1:0] tx_count;
  logic             rx_push, rx_pop, rx_full, rx_empty;
  logic [9:0]       rx_head, rx_word;
  logic [CNT_W-1:0] rx_count;

  // Two independent character stores.
  char_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo_u (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .push     (tx_push),
    .wdata    (reg_wdata[7:0]),
    .pop      (tx_pop),
    .head     (tx_head),
    .full     (tx_full),
    .empty    (tx_empty),
    .count    (tx_count)
  );

  char_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) rx_fifo_u (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .push     (rx_push),
    .wdata    (rx_word),
    .pop      (rx_pop),
    .head     (rx_head),
    .full     (rx_full),
    .empty    (rx_empty),
    .count    (rx_count)
  );

  assign tx_push = reg_wr && is_reg(reg_addr, serial_port_pkg::TX_DATA_IDX);
  assign rx_pop  = reg_rd && is_reg(reg_addr, serial_port_pkg::RX_DATA_IDX);

  // Transmitter.
  frame_state_t tx_state_q;
  logic [3:0]   tx_sub_q;
  logic [2:0]   tx_bit_q;
  logic [7:0]   tx_shift_q;
  logic         tx_par_q;
  logic         txd_q;
  logic         tx_last;
  logic         tx_end;

  assign tx_pop  = tick && (tx_state_q == ST_IDLE) && tx_en && !tx_empty;
  assign tx_last = tick && (tx_sub_q == serial_port_pkg::LAST_SUB_TICK);
  assign tx_end  = tx_last && (tx_state_q == ST_STOP)
                   && !(stop2 && tx_bit_q == 3'h0) && tx_empty;

  // Each bit lasts sixteen ticks; the line value changes only at bit edges.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_q <= ST_IDLE;
      tx_sub_q   <= 4'h0;
      tx_bit_q   <= 3'h0;
      tx_shift_q <= 8'h00;
      tx_par_q   <= 1'b0;
      txd_q      <= 1'b1;
    end else if (tick) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      case (tx_state_q)
        ST_IDLE: begin
          tx_sub_q <= 4'h0;
          txd_q    <= 1'b1;
          if (tx_pop) begin
            tx_shift_q <= char7 ? {1'b0, tx_head[6:0]} : tx_head;
            tx_par_q   <= (^(char7 ? {1'b0, tx_head[6:0]} : tx_head))
                          ^ par_odd;
            txd_q      <= 1'b0;
            tx_state_q <= ST_START;
          end
        end
        ST_START: begin
          if (tx_last) begin
            txd_q      <= tx_shift_q[0];
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_bit_q   <= 3'h0;
            tx_state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_last) begin
            if (tx_bit_q == (char7 ? 3'h6 : 3'h7)) begin
              tx_bit_q <= 3'h0;
              if (par_en) begin
                txd_q      <= tx_par_q;
                tx_state_q <= ST_PARITY;
              end else begin
                txd_q      <= 1'b1;
                tx_state_q <= ST_STOP;
              end
            end else begin
              tx_bit_q   <= tx_bit_q + 3'h1;
              txd_q      <= tx_shift_q[0];
              tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            end
          end
        end
        ST_PARITY: begin
          if (tx_last) begin
            txd_q      <= 1'b1;
            tx_state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_last) begin
            if (stop2 && tx_bit_q == 3'h0) begin
              tx_bit_q <= 3'h1;
            end else begin
              tx_state_q <= ST_IDLE;
            end
          end
        end
        default: tx_state_q <= ST_IDLE;
      endcase
    end
  end

  // Receiver.
  frame_state_t rx_state_q;
  logic [3:0]   rx_sub_q;
  logic [2:0]   rx_bit_q;
  logic [7:0]   rx_shift_q;
  logic         rx_pbit_q;
  logic         rxd;
  logic         rx_done;
  logic [7:0]   rx_data;
  logic         rx_fer;
  logic         rx_per;
  logic         rx_brk;

  assign rxd     = rxd_sync_q[1];
  assign rx_done = tick && (rx_state_q == ST_STOP)
                   && (rx_sub_q == serial_port_pkg::LAST_SUB_TICK);
  assign rx_data = char7 ? {1'b0, rx_shift_q[7:1]} : rx_shift_q;
  assign rx_fer  = !rxd;
  assign rx_per  = par_en && ((^rx_data ^ rx_pbit_q) != par_odd);
  assign rx_brk  = rx_fer && (rx_data == 8'h00) && !(par_en && rx_pbit_q);
  assign rx_word = {rx_per, rx_fer, rx_data};

  // Nothing enters the store while overrun stands or when it is full.
  assign rx_push = rx_done && !rx_full && !overrun_q;

  // Hunt for a low level, confirm it mid bit, then sample every sixteen.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_q <= ST_IDLE;
      rx_sub_q   <= 4'h0;
      rx_bit_q   <= 3'h0;
      rx_shift_q <= 8'h00;
      rx_pbit_q  <= 1'b0;
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_state_q)
        ST_IDLE: begin
          rx_sub_q <= 4'h0;
          if (rx_en && !overrun_q && !rxd) begin
            rx_state_q <= ST_START;
          end
        end
        ST_START: begin
          if (rx_sub_q == serial_port_pkg::MID_START_TICK) begin
            rx_sub_q   <= 4'h0;
            rx_bit_q   <= 3'h0;
            rx_state_q <= rxd ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_sub_q == serial_port_pkg::LAST_SUB_TICK) begin
            rx_shift_q <= {rxd, rx_shift_q[7:1]};
            rx_bit_q   <= rx_bit_q + 3'h1;
            if (rx_bit_q == (char7 ? 3'h6 : 3'h7)) begin
              rx_state_q <= par_en ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (rx_sub_q == serial_port_pkg::LAST_SUB_TICK) begin
            rx_pbit_q  <= rxd;
            rx_state_q <= ST_STOP;
          end
        end
        ST_STOP: begin
          // Second stop bit is not waited for; idle hunting covers it.
          if (rx_done) begin
            rx_state_q <= ST_IDLE;
          end
        end
        default: rx_state_q <= ST_IDLE;
      endcase
    end
  end

  // Overrun flag; a fresh overrun beats a clearing write in the same cycle.
  logic lsr_wr;
  logic lsr_rd;
  logic ovr_set;
  assign lsr_wr = reg_wr && is_reg(reg_addr, serial_port_pkg::LINE_STATUS_IDX);
  assign lsr_rd = reg_rd && is_reg(reg_addr, serial_port_pkg::LINE_STATUS_IDX);
  assign ovr_set = rx_done && rx_full && !overrun_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      overrun_q      <= 1'b0;
      overrun_seen_q <= 1'b0;
    end else begin
      if (ovr_set) begin
        overrun_q      <= 1'b1;
        overrun_seen_q <= 1'b0;
      end else if (lsr_wr && overrun_seen_q
                   && !reg_wdata[serial_port_pkg::OVERRUN_BIT]) begin
        overrun_q      <= 1'b0;
        overrun_seen_q <= 1'b0;
      end else if (lsr_rd && overrun_q) begin
        overrun_seen_q <= 1'b1;
      end
    end
  end

  // Sticky events for the interrupt line.
  always_comb begin
    ev_set = '0;
    ev_set[serial_port_pkg::EV_RX_READY] = rx_push;
    ev_set[serial_port_pkg::EV_FRAMING]  = rx_done && rx_fer;
    ev_set[serial_port_pkg::EV_PARITY]   = rx_done && rx_per;
    ev_set[serial_port_pkg::EV_BREAK]    = rx_done && rx_brk;
    ev_set[serial_port_pkg::EV_RX_FULL]  = rx_push && !rx_pop
                            && (rx_count == CNT_W'(FIFO_DEPTH - 1));
    ev_set[serial_port_pkg::EV_TX_END]   = tx_end;
    ev_set[serial_port_pkg::EV_OVERRUN]  = ovr_set;
  end

  logic ev_clr_wr;
  assign ev_clr_wr = reg_wr
                     && is_reg(reg_addr, serial_port_pkg::EVENT_STATUS_IDX);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      events_q <= '0;
    end else begin
      events_q <= (events_q & ~(ev_clr_wr ? reg_wdata[EV_W_L:0] : '0))
                  | ev_set;
    end
  end

  // Configuration writes; receive enable does not touch the overrun flag.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      format_q   <= serial_port_pkg::FORMAT_RESET;
      control_q  <= serial_port_pkg::CONTROL_RESET;
      baud_div_q <= serial_port_pkg::BAUD_RESET;
      mask_q     <= serial_port_pkg::MASK_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        serial_port_pkg::FORMAT_SETUP_IDX:  format_q   <= reg_wdata;
        serial_port_pkg::CONTROL_SETUP_IDX: control_q  <= reg_wdata;
        serial_port_pkg::BAUD_DIV_IDX:      baud_div_q <= reg_wdata;
        serial_port_pkg::EVENT_MASK_IDX:    mask_q <= reg_wdata[EV_W_L:0];
        default: ;
      endcase
    end
  end

  // Read data stands in the cycle after the strobe and is zero otherwise.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= 16'h0000;
      if (reg_rd) begin
        case (reg_addr)
          serial_port_pkg::FORMAT_SETUP_IDX:  reg_rdata <= format_q;
          serial_port_pkg::CONTROL_SETUP_IDX: reg_rdata <= control_q;
          serial_port_pkg::BAUD_DIV_IDX:      reg_rdata <= baud_div_q;
          serial_port_pkg::RX_DATA_IDX:
            reg_rdata <= rx_empty ? 16'h0000 : {6'h00, rx_head};
          serial_port_pkg::EVENT_STATUS_IDX:
            reg_rdata <= {{(16 - serial_port_pkg::EV_W){1'b0}}, events_q};
          serial_port_pkg::EVENT_MASK_IDX:
            reg_rdata <= {{(16 - serial_port_pkg::EV_W){1'b0}}, mask_q};
          serial_port_pkg::FIFO_COUNT_IDX:
            reg_rdata <= {3'h0, 5'(tx_count), 3'h0, 5'(rx_count)};
          serial_port_pkg::LINE_STATUS_IDX:
            reg_rdata <= {15'h0000, overrun_q};
          default: reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Outputs come straight from flip-flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(events_q & mask_q);
    end
  end
  assign transmit_pin = txd_q;

  // Checks.
  lsr_upper_zero_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    lsr_rd |=> reg_rdata[15:1] == 15'h0000 && reg_rdata[0] == $past(overrun_q))
    else $error("line status upper bits not zero");

  overrun_set_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rx_done && rx_full |=> overrun_q)
    else $error("overrun flag not set on full receive store");

  overrun_clear_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    $fell(overrun_q) |-> $past(lsr_wr) && !$past(reg_wdata[0])
                         && $past(overrun_seen_q))
    else $error("overrun flag cleared without proper write");

  overrun_hold_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    overrun_q && !lsr_wr |=> overrun_q)
    else $error("overrun flag lost without a write");

  overrun_drop_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    overrun_q && !rx_pop |=> $stable(rx_count))
    else $error("receive store changed during overrun");

  fifo_bound_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    rx_count <= CNT_W'(FIFO_DEPTH) && tx_count <= CNT_W'(FIFO_DEPTH))
    else $error("fifo count beyond depth");

  clock_select_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !ext_clk |-> tick == baud_tick)
    else $error("tick not from baud generator");

  tx_idle_high_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tx_state_q == ST_IDLE && !tx_pop |=> transmit_pin)
    else $error("line not high while idle");

  tx_start_low_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    tx_pop |=> !transmit_pin && tx_state_q == ST_START)
    else $error("start bit not low");

endmodule
`default_nettype wire

// ### testbench/remote_serial_end.sv
`default_nettype none
// Far-end transceiver that faces the port across the serial line.
module remote_serial_end (
  input  wire logic core_clk,
  input  wire logic transmit_pin,
  output logic      receive_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cycles = 16;

  // The line rests at mark between frames.
  initial receive_pin = 1'b1;

  // Sends n bits of a prepared frame, first bit first, one bit time each.
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk) receive_pin <= bits[i];
      repeat (bit_cycles - 1) @(posedge core_clk);
    end
    @(posedge core_clk) receive_pin <= 1'b1;
  endtask

  // Samples n bits at mid-bit, starting from the falling start edge.
  task automatic recv(input int n, output logic [11:0] bits);
    bits = 12'h000;
    @(negedge transmit_pin);
    repeat (bit_cycles / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = transmit_pin;
      repeat (bit_cycles) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// ### testbench/fifo_serial_port_tb.sv
`default_nettype none
module fifo_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] A_CTL = serial_port_pkg::CONTROL_SETUP_IDX;
  localparam logic [3:0] A_TX  = serial_port_pkg::TX_DATA_IDX;
  localparam logic [3:0] A_RX  = serial_port_pkg::RX_DATA_IDX;
  localparam logic [3:0] A_LS  = serial_port_pkg::LINE_STATUS_IDX;
  logic        core_clk;
  logic        rst_n;
  logic        reg_wr;
  logic        reg_rd;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] v;
  logic        transmit_pin;
  logic        receive_pin;
  logic        irq;
  logic [11:0] fr;
  logic [11:0] got;
  logic [31:0] seed = 32'h00000015;
  logic [1:0]  ext_cnt = 2'h0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n;

  fifo_serial_port dut (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .receive_pin(receive_pin),
    .serial_clock_pin(ext_cnt[1]), .transmit_pin(transmit_pin),
    .irq(irq));
  remote_serial_end far (.core_clk(core_clk), .transmit_pin(transmit_pin),
    .receive_pin(receive_pin));

  // Clock, and an external sixteen-times clock at a quarter of its rate.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) ext_cnt <= ext_cnt + 2'h1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Builds the expected frame; f is {seven bits, parity, two stops}.
  function automatic logic [11:0] frame(input logic [7:0] d,
                                        input logic [2:0] f, output int k);
    logic [11:0] b;
    b = 12'h000;
    for (k = 0; k < (f[2] ? 7 : 8); k++) begin
      b[k + 1] = d[k];
    end
    k = k + 1;
    if (f[1]) begin
      b[k] = f[2] ? ^d[6:0] : ^d;
      k = k + 1;
    end
    b[k] = 1'b1;
    b[k + 1] = f[0];
    k = k + 1 + int'(f[0]);
    return b;
  endfunction

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  // One character out and one back in the given format.
  task automatic exchange(input logic [2:0] f, input logic [7:0] d);
    wr(serial_port_pkg::FORMAT_SETUP_IDX,
       {9'h000, f[2], f[1], 1'b0, f[0], 3'h0});
    fr = frame(d, f, n);
    fork
      far.recv(n, got);
      wr(A_TX, {8'h00, d});
    join
    check("tx frame", {4'h0, got}, {4'h0, fr});
    far.send(fr, n);
    repeat (8) @(posedge core_clk);
    rd(A_RX, v);
    check("rx data", v, {8'h00, d & (f[2] ? 8'h7F : 8'hFF)});
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A hang cuts the run short well past the expected length.
  initial begin
    repeat (60000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(A_LS, 16'hFFFE);
    rd(A_LS, v);
    check("line status", v, 16'h0000);
    rd(4'hF, v);
    check("unmapped", v, 16'h0000);
    wr(A_CTL, 16'h0030);
    for (int f = 0; f < 8; f++) begin
      seed = xs(seed);
      exchange(f[2:0], seed[7:0]);
    end
    wr(A_CTL, 16'h0032);
    far.bit_cycles = 64;
    exchange(3'h3, 8'hA5);
    wr(A_CTL, 16'h0030);
    wr(serial_port_pkg::FORMAT_SETUP_IDX, 16'h0000);
    far.bit_cycles = 16;
    fr = frame(8'h5A, 3'h0, n);
    fr[9] = 1'b0;
    far.send(fr, n);
    repeat (8) @(posedge core_clk);
    rd(A_RX, v);
    check("framing error", v, 16'h015A);
    wr(serial_port_pkg::EVENT_MASK_IDX, 16'h0040);
    for (int i = 0; i < 18; i++) begin
      fr = frame(i[7:0] + 8'h30, 3'h0, n);
      far.send(fr, n);
    end
    repeat (8) @(posedge core_clk);
    rd(A_LS, v);
    check("overrun set", v, 16'h0001);
    check("irq level", {15'h0000, irq}, 16'h0001);
    rd(serial_port_pkg::FIFO_COUNT_IDX, v);
    check("rx count", v, 16'h0010);
    wr(A_LS, 16'h0001);
    wr(A_CTL, 16'h0020);
    rd(A_LS, v);
    check("overrun kept", v, 16'h0001);
    rd(A_RX, v);
    check("oldest kept", v, 16'h0030);
    wr(A_LS, 16'h0000);
    rd(A_LS, v);
    check("overrun cleared", v, 16'h0000);
    wr(A_CTL, 16'h0000);
    wr(A_TX, 16'h0011);
    wr(A_TX, 16'h0022);
    rd(serial_port_pkg::FIFO_COUNT_IDX, v);
    check("fifo counts", v, 16'h020F);
    wr(serial_port_pkg::EVENT_STATUS_IDX, 16'h0040);
    repeat (2) @(posedge core_clk);
    check("irq cleared", {15'h0000, irq}, 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
